// >>> csm_manager.sv
// calibration serial manager: registers, arbitration, temperature poll
`timescale 1ns/10ps
`default_nettype none
module csm_manager
  import csm_pkg::*;
#(
  parameter int POLL_CYCLES = POLL_CYC,
  parameter int QDIV        = I2C_QDIV
) (
  // system clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  // link clock of the serial engine
  input  wire logic        link_clk_in,
  // carrier register port
  input  wire logic [7:0]  reg_addr_in,
  input  wire logic [15:0] reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic      [15:0] reg_rdata_out,
  // internal serial bus
  output logic             scl_out,
  output logic             scl_oe_n_out,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe_n_out,
  // identity store pins
  output logic             prom_cs_out,
  output logic             prom_clk_out,
  input  wire logic        prom_serial_io_in,
  output logic             prom_serial_io_out,
  output logic             prom_serial_io_oe_n_out,
  // converted board temperature
  output logic      [7:0]  temp_degc_out
);
  localparam int PW = $clog2(POLL_CYCLES + 1);

  csm_st_t           st_r;
  csm_op_t           kind_r, kind_nxt;
  csm_cmd_t          cmd_r, cmd_nxt;
  csm_rsp_t          rsp;
  logic              req_tgl_r, done_seen_r, done_s, io_s, done_edge;
  logic              done_tgl;
  logic              issue;
  logic              inhibit_r;
  logic        [9:0] temp_raw_r;
  logic signed [9:0] temp_div;
  logic       [15:0] trim_r;
  logic        [7:0] ptr_r;
  logic       [15:0] word_r;
  logic              op_done_r, err_r;
  logic              trim_pend_r, rb_pend_r, store_pend_r, fetch_pend_r;
  logic              temp_pend_r;
  logic     [PW-1:0] poll_r;
  logic        [2:0] prom_r;
  logic              wr_temp, wr_trim, wr_ctl, wr_word, wr_prom;
  logic              poll_wrap;

  assign wr_temp = reg_wr_in && reg_addr_in == REG_TEMP;
  assign wr_trim = reg_wr_in && reg_addr_in == REG_TRIM;
  assign wr_ctl  = reg_wr_in && reg_addr_in == REG_EE_CTL;
  assign wr_word = reg_wr_in && reg_addr_in == REG_EE_WORD;
  assign wr_prom = reg_wr_in && reg_addr_in == REG_PROM;

  // engine runs on the link clock; the command is held stable while busy
  csm_i2c_engine #(.QDIV(QDIV)) u_engine (
    .link_clk_in  (link_clk_in),
    .rst_n_in     (rst_n_in),
    .req_tgl_in   (req_tgl_r),
    .cmd_in       (cmd_r),
    .done_tgl_out (done_tgl),
    .rsp_out      (rsp),
    .scl_out      (scl_out),
    .scl_oe_n_out (scl_oe_n_out),
    .sda_in       (sda_in),
    .sda_out      (sda_out),
    .sda_oe_n_out (sda_oe_n_out)
  );

  // done toggle and identity pin cross into the system clock domain

  csm_sync #(.W(2)) u_sync (
    .clk_in (clk_in),
    .d_in   ({done_tgl, prom_serial_io_in}),
    .q_out  ({done_s, io_s})
  );

  // response word is only read after the toggle has crossed, so it is stable
  assign done_edge = (st_r == ST_BUSY) && (done_s != done_seen_r);

  // temperature poll timer
  assign poll_wrap = (poll_r == PW'(POLL_CYCLES - 1));

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      poll_r <= '0;
    end else if (inhibit_r || poll_wrap) begin
      poll_r <= '0;
    end else begin
      poll_r <= poll_r + PW'(1);
    end
  end

  // arbitration: trim work first, then EEPROM, then the poll
  always_comb begin
    issue    = 1'b1;
    kind_nxt = OP_TEMP;
    cmd_nxt  = '0;
    if (trim_pend_r) begin
      kind_nxt = OP_TRIM_WR;
      cmd_nxt  = '{dev: DEV_TRIM, wr_cnt: 2'd2,
                   wr_data: {trim_r, 8'h00}, rd_cnt: 2'd0};
    end else if (rb_pend_r) begin
      kind_nxt = OP_TRIM_RD;
      cmd_nxt  = '{dev: DEV_TRIM, wr_cnt: 2'd0, wr_data: 24'h0,
                   rd_cnt: 2'd2};
    end else if (store_pend_r) begin
      kind_nxt = OP_STORE;
      cmd_nxt  = '{dev: DEV_EEPROM, wr_cnt: 2'd3,
                   wr_data: {ptr_r, word_r}, rd_cnt: 2'd0};
    end else if (fetch_pend_r) begin
      kind_nxt = OP_FETCH;
      cmd_nxt  = '{dev: DEV_EEPROM, wr_cnt: 2'd1,
                   wr_data: {ptr_r, 16'h0000}, rd_cnt: 2'd2};
    end else if (temp_pend_r && !inhibit_r) begin
      cmd_nxt  = '{dev: DEV_SENSOR, wr_cnt: 2'd0, wr_data: 24'h0,
                   rd_cnt: 2'd2};
    end else begin
      issue = 1'b0;
    end
  end

  // transaction sequencer
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      st_r        <= ST_IDLE;
      kind_r      <= OP_TEMP;
      cmd_r       <= '0;
      req_tgl_r   <= 1'b0;
      done_seen_r <= 1'b0;
    end else begin
      case (st_r)
        ST_IDLE: begin
          if (issue) begin
            kind_r    <= kind_nxt;
            cmd_r     <= cmd_nxt;
            req_tgl_r <= ~req_tgl_r;
            st_r      <= ST_BUSY;
          end
        end
        ST_BUSY: begin
          if (done_edge) begin
            done_seen_r <= done_s;
            st_r        <= ST_IDLE;
          end
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  // pending requests; a new request beats the clear of the one issued
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      trim_pend_r  <= 1'b0;
      rb_pend_r    <= 1'b1;
      store_pend_r <= 1'b0;
      fetch_pend_r <= 1'b0;
      temp_pend_r  <= 1'b0;
    end else begin
      if (st_r == ST_IDLE && issue) begin
        case (kind_nxt)
          OP_TRIM_WR: trim_pend_r  <= 1'b0;
          OP_TRIM_RD: rb_pend_r    <= 1'b0;
          OP_STORE:   store_pend_r <= 1'b0;
          OP_FETCH:   fetch_pend_r <= 1'b0;
          default:    temp_pend_r  <= 1'b0;
        endcase
      end
      if (wr_trim && op_done_r)
        trim_pend_r <= 1'b1;
      if (done_edge && kind_r == OP_TRIM_WR)
        rb_pend_r <= 1'b1;
      if (wr_ctl && op_done_r) begin
        // store wins if both request bits are written together
        store_pend_r <= reg_wdata_in[EE_STORE_BIT];
        fetch_pend_r <= reg_wdata_in[EE_FETCH_BIT] &&
                        !reg_wdata_in[EE_STORE_BIT];
      end
      if (inhibit_r)
        temp_pend_r <= 1'b0;
      else if (poll_wrap)
        temp_pend_r <= 1'b1;
    end
  end

  // completion flag: low from request to the end of its last transaction
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      op_done_r <= 1'b0;
    end else if ((wr_trim || (wr_ctl && (reg_wdata_in[EE_STORE_BIT] ||
                 reg_wdata_in[EE_FETCH_BIT]))) && op_done_r) begin
      op_done_r <= 1'b0;
    end else if (done_edge && kind_r inside {OP_TRIM_RD, OP_STORE,
                                              OP_FETCH}) begin
      op_done_r <= 1'b1;
    end
  end

  // error flag follows every bus user, polls included
  always_ff @(posedge clk_in) begin
    if (!rst_n_in)
      err_r <= 1'b0;
    else if (done_edge)
      err_r <= rsp.err;
  end

  // trim register: written value is replaced by what the pots report
  always_ff @(posedge clk_in) begin
    if (!rst_n_in)
      trim_r <= {TRIM_RESET, TRIM_RESET};
    else if (done_edge && kind_r == OP_TRIM_RD && !rsp.err)
      trim_r <= rsp.rd_data;
    else if (wr_trim && op_done_r)
      trim_r <= reg_wdata_in;
  end

  // EEPROM pointer and data word
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      ptr_r  <= 8'h00;
      word_r <= 16'h0000;
    end else begin
      if (wr_ctl && op_done_r)
        ptr_r <= reg_wdata_in[EE_PTR_LSB +: EE_PTR_W];
      // fetched word has priority over a software write in the same cycle
      if (done_edge && kind_r == OP_FETCH)
        word_r <= rsp.rd_data;
      else if (wr_word)
        word_r <= reg_wdata_in;
    end
  end

  // temperature register and conversion
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      inhibit_r  <= 1'b0;
      temp_raw_r <= 10'h000;
    end else begin
      if (wr_temp)
        inhibit_r <= reg_wdata_in[TEMP_INH_BIT];
      if (done_edge && kind_r == OP_TEMP && !rsp.err)
        temp_raw_r <= rsp.rd_data[SENSOR_LSB +: 10];
    end
  end

  // below-zero raw forms a signed value equal to magnitude minus 512
  assign temp_div = $signed(temp_raw_r) / 10'sd4;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in)
      temp_degc_out <= 8'h00;
    else
      temp_degc_out <= temp_div[7:0];
  end

  // identity store port: bit-banged by software, data pin open drain
  always_ff @(posedge clk_in) begin
    if (!rst_n_in)
      prom_r <= PROM_RESET;
    else if (wr_prom)
      prom_r <= reg_wdata_in[2:0];
  end

  assign prom_cs_out             = prom_r[PROM_CS_BIT];
  assign prom_clk_out            = prom_r[PROM_CLK_BIT];
  assign prom_serial_io_out      = 1'b0;
  assign prom_serial_io_oe_n_out = prom_r[PROM_IO_BIT];

  // register read, answered on the edge after the strobe
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      reg_rdata_out <= 16'h0000;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        REG_TEMP:    reg_rdata_out <= {inhibit_r, 5'h00, temp_raw_r};
        REG_TRIM:    reg_rdata_out <= trim_r;
        REG_EE_CTL:  reg_rdata_out <= {op_done_r, err_r, 5'h00, ptr_r,
                                       1'b0};
        REG_EE_WORD: reg_rdata_out <= word_r;
        REG_PROM:    reg_rdata_out <= {13'h0000, prom_r[PROM_CS_BIT],
                                       prom_r[PROM_CLK_BIT], io_s};
        default:     reg_rdata_out <= 16'h0000;
      endcase
    end
  end

  // checks
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);

  sequence s_ee_start;
    wr_ctl && op_done_r &&
      (reg_wdata_in[EE_STORE_BIT] || reg_wdata_in[EE_FETCH_BIT]);
  endsequence

  sequence s_finish(csm_op_t k);
    done_edge && kind_r == k;
  endsequence

  ee_start_drop_a: assert property (s_ee_start |=> !op_done_r)
    else $error("done did not drop on EEPROM start");

  trim_start_drop_a: assert property (
    wr_trim && op_done_r |=> !op_done_r ##1 (trim_pend_r ||
                             st_r == ST_BUSY))
    else $error("trim write did not drop done");

  trim_wr_hold_a: assert property (
    s_finish(OP_TRIM_WR) |=> !op_done_r && rb_pend_r)
    else $error("done rose before trim read-back");

  fetch_valid_a: assert property (
    s_finish(OP_FETCH) |=> op_done_r && word_r == $past(rsp.rd_data))
    else $error("fetch done without fetched word");

  busy_ignore_a: assert property (
    wr_ctl && !op_done_r |=> $stable(ptr_r) && !(store_pend_r &&
                             !$past(store_pend_r)))
    else $error("request taken while busy");

  one_at_time_a: assert property (
    $changed(req_tgl_r) |-> $past(st_r) == ST_IDLE && st_r == ST_BUSY)
    else $error("serial transactions overlap");

  err_follow_a: assert property (done_edge |=> err_r == $past(rsp.err))
    else $error("error flag not from latest transaction");

  poll_due_a: assert property (
    poll_wrap && !inhibit_r |=> temp_pend_r || st_r == ST_BUSY)
    else $error("temperature poll not raised");

  inhibit_quiet_a: assert property (
    inhibit_r && st_r == ST_IDLE |=> !(st_r == ST_BUSY && kind_r == OP_TEMP))
    else $error("poll issued while inhibited");

  temp_pos_a: assert property (
    !temp_raw_r[TEMP_NEG_BIT] && $stable(temp_raw_r) |=>
      temp_degc_out == {1'b0, $past(temp_raw_r[8:2])})
    else $error("positive temperature not raw over four");

  prom_drive_a: assert property (
    wr_prom |=> prom_cs_out == $past(reg_wdata_in[PROM_CS_BIT]) &&
                prom_serial_io_oe_n_out == $past(reg_wdata_in[PROM_IO_BIT]))
    else $error("identity port pins not driven from write");
endmodule
`default_nettype wire

// >>> csm_pkg.sv
// package: register map, field layout, timing and carriers of the block
package csm_pkg;
  // register offsets
  localparam logic [7:0]  REG_TEMP     = 8'h44;
  localparam logic [7:0]  REG_TRIM     = 8'h46;
  localparam logic [7:0]  REG_EE_CTL   = 8'h48;
  localparam logic [7:0]  REG_EE_WORD  = 8'h4a;
  localparam logic [7:0]  REG_PROM     = 8'hfe;
  // field positions
  localparam int          TEMP_INH_BIT = 15;
  localparam int          TEMP_NEG_BIT = 9;
  localparam int          EE_DONE_BIT  = 15;
  localparam int          EE_ERR_BIT   = 14;
  localparam int          EE_STORE_BIT = 13;
  localparam int          EE_FETCH_BIT = 12;
  localparam int          EE_PTR_LSB   = 1;
  localparam int          EE_PTR_W     = 8;
  localparam int          PROM_CS_BIT  = 2;
  localparam int          PROM_CLK_BIT = 1;
  localparam int          PROM_IO_BIT  = 0;
  localparam int          SENSOR_LSB   = 6;
  // reset values
  localparam logic [7:0]  TRIM_RESET   = 8'h80;
  localparam logic [2:0]  PROM_RESET   = 3'h1;
  // identity store layout, held in the external serial part
  localparam int          ID_BASIC_WORDS = 16;
  localparam int          ID_EXT_WORDS   = 64;
  localparam int          IDW_SYNC       = 0;
  localparam int          IDW_MODULE     = 1;
  localparam int          IDW_REVISION   = 2;
  localparam int          IDW_CHARACTER  = 3;
  localparam int          IDW_EXT_SYNC   = 16;
  localparam int          IDW_VENDOR     = 17;
  localparam int          IDW_DEV_TYPE   = 18;
  localparam logic [15:0] ID_RSVD_WORD   = 16'h0000;
  localparam int          REV_FW_MAJ_LSB = 12;
  localparam int          REV_FW_MIN_LSB = 8;
  localparam int          REV_HW_MAJ_LSB = 4;
  localparam int          REV_HW_MIN_LSB = 0;
  // timing
  localparam int          CLK_KHZ      = 40000;
  localparam int          POLL_MS      = 500;
  localparam int          POLL_CYC     = POLL_MS * CLK_KHZ;
  localparam int          LINK_KHZ     = 31250;
  localparam int          BIT_KHZ      = 100;
  localparam int          I2C_QDIV     = LINK_KHZ / (4 * BIT_KHZ);
  // serial device addresses
  localparam logic [6:0]  DEV_EEPROM   = 7'h50;
  localparam logic [6:0]  DEV_TRIM     = 7'h2c;
  localparam logic [6:0]  DEV_SENSOR   = 7'h48;

  typedef struct packed {
    logic [6:0]  dev;
    logic [1:0]  wr_cnt;
    logic [23:0] wr_data;
    logic [1:0]  rd_cnt;
  } csm_cmd_t;

  typedef struct packed {
    logic [15:0] rd_data;
    logic        err;
  } csm_rsp_t;

  typedef enum logic [4:0] {
    OP_TRIM_WR = 5'b00001,
    OP_TRIM_RD = 5'b00010,
    OP_STORE   = 5'b00100,
    OP_FETCH   = 5'b01000,
    OP_TEMP    = 5'b10000
  } csm_op_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_BUSY = 2'b10
  } csm_st_t;
endpackage

// >>> csm_sync.sv
// two-flop level synchroniser
`timescale 1ns/10ps
`default_nettype none
module csm_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk_in) begin
    meta_r <= d_in;
    q_out  <= meta_r;
  end
endmodule
`default_nettype wire

// >>> csm_i2c_engine.sv
// two-wire bus master on the link clock, one transaction per request toggle
`timescale 1ns/10ps
`default_nettype none
module csm_i2c_engine
  import csm_pkg::*;
#(
  parameter int QDIV = I2C_QDIV
) (
  // link clock and reset
  input  wire logic     link_clk_in,
  input  wire logic     rst_n_in,
  // request and answer
  input  wire logic     req_tgl_in,
  input  wire csm_cmd_t cmd_in,
  output logic          done_tgl_out,
  output csm_rsp_t      rsp_out,
  // bus pins
  output logic          scl_out,
  output logic          scl_oe_n_out,
  input  wire logic     sda_in,
  output logic          sda_out,
  output logic          sda_oe_n_out
);
  typedef enum logic [3:0] {
    E_IDLE = 4'b0001, E_START = 4'b0010, E_BYTE = 4'b0100, E_STOP = 4'b1000
  } csm_eng_t;

  csm_eng_t    st_r;
  csm_cmd_t    cmd_r;
  logic        lrst_n, req_s, sda_s, seen_r, rd_seg_r, rdb_r, nack_r;
  logic        scl_lo_r, sda_lo_r;
  logic [1:0]  q_r, left_r;
  logic [3:0]  bit_r;
  logic [7:0]  div_r, sh_r;
  logic [23:0] wq_r;
  logic        tick;

  csm_sync #(.W(3)) u_sync (
    .clk_in (link_clk_in),
    .d_in   ({rst_n_in, req_tgl_in, sda_in}),
    .q_out  ({lrst_n, req_s, sda_s})
  );

  assign tick         = (div_r == 8'(QDIV - 1));
  assign scl_out      = 1'b0;
  assign sda_out      = 1'b0;
  assign scl_oe_n_out = ~scl_lo_r;
  assign sda_oe_n_out = ~sda_lo_r;

  always_ff @(posedge link_clk_in) begin
    if (!lrst_n) begin
      st_r <= E_IDLE; cmd_r <= '0; seen_r <= 1'b0; done_tgl_out <= 1'b0;
      rsp_out <= '0; rd_seg_r <= 1'b0; rdb_r <= 1'b0; nack_r <= 1'b0;
      scl_lo_r <= 1'b0; sda_lo_r <= 1'b0; q_r <= 2'd0; left_r <= 2'd0;
      bit_r <= 4'd0; div_r <= 8'd0; sh_r <= 8'h00; wq_r <= 24'h0;
    end else if (st_r == E_IDLE) begin
      q_r <= 2'd0;
      div_r <= 8'd0;
      if (req_s != seen_r) begin
        seen_r   <= req_s;
        cmd_r    <= cmd_in;
        wq_r     <= cmd_in.wr_data;
        rsp_out  <= '0;
        rd_seg_r <= (cmd_in.wr_cnt == 2'd0);
        st_r     <= E_START;
      end
    end else begin
      div_r <= tick ? 8'd0 : div_r + 8'd1;
      if (tick) begin
        q_r <= q_r + 2'd1;
        case (st_r)
          E_START: begin
            case (q_r)
              2'd0: sda_lo_r <= 1'b0;
              2'd1: scl_lo_r <= 1'b0;
              2'd2: sda_lo_r <= 1'b1;
              default: begin
                scl_lo_r <= 1'b1; bit_r <= 4'd0; rdb_r <= 1'b0;
                sh_r   <= {cmd_r.dev, rd_seg_r};
                left_r <= rd_seg_r ? cmd_r.rd_cnt : cmd_r.wr_cnt;
                st_r   <= E_BYTE;
              end
            endcase
          end
          E_BYTE: begin
            case (q_r)
              // ack slot: master acks every read byte but the last
              2'd0: sda_lo_r <= (bit_r == 4'd8) ? (rdb_r && left_r != 2'd0)
                                                : (!rdb_r && !sh_r[7]);
              2'd1: scl_lo_r <= 1'b0;
              2'd2: begin
                if (bit_r == 4'd8) nack_r <= sda_s;
                else sh_r <= {sh_r[6:0], sda_s};
              end
              default: begin
                scl_lo_r <= 1'b1;
                bit_r    <= bit_r + 4'd1;
                if (bit_r == 4'd8) begin
                  bit_r <= 4'd0;
                  if (rdb_r) rsp_out.rd_data <= {rsp_out.rd_data[7:0], sh_r};
                  if (!rdb_r && nack_r) begin
                    rsp_out.err <= 1'b1;
                    st_r <= E_STOP;
                  end else if (left_r != 2'd0) begin
                    left_r <= left_r - 2'd1;
                    rdb_r  <= rd_seg_r;
                    sh_r   <= rd_seg_r ? 8'hff : wq_r[23:16];
                    wq_r   <= {wq_r[15:0], 8'h00};
                  end else if (!rd_seg_r && cmd_r.rd_cnt != 2'd0) begin
                    rd_seg_r <= 1'b1;
                    st_r <= E_START;
                  end else st_r <= E_STOP;
                end
              end
            endcase
          end
          default: begin
            case (q_r)
              2'd0: sda_lo_r <= 1'b1;
              2'd1: scl_lo_r <= 1'b0;
              2'd2: sda_lo_r <= 1'b0;
              default: begin
                st_r <= E_IDLE;
                done_tgl_out <= ~done_tgl_out;
              end
            endcase
          end
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// >>> csm_i2c_model.sv
// two-wire partner: calibration store, trim pots, temperature sensor
`timescale 1ns/10ps
`default_nettype none
module csm_i2c_model (
  // bus wires
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_oe_n_out,
  // scenario control
  input  wire logic        nack_in,
  input  wire logic [15:0] temp_in
);
  logic [15:0] ee [0:255];
  logic [15:0] rv;
  logic [7:0]  sh, ptr, ob;
  logic [7:0]  fs = 8'h80;
  logic [7:0]  os = 8'h80;
  logic [6:0]  dev;
  logic        rd, hit;
  int          bc, nb;
  initial sda_oe_n_out = 1'b1;
  always @(negedge sda_in) if (scl_in) begin
    bc = 0;
    nb = 0;
    rd = 0;
  end
  always @(posedge scl_in) begin
    // master nack ends a read, so the stop is not blocked
    if (bc == 8 && rd && sda_in)
      rd = 0;
    sh = {sh[6:0], sda_in};
    bc = bc + 1;
  end
  always @(negedge scl_in) begin
    if (bc == 8) begin
      if (!rd) begin
        if (nb == 0) begin
          dev = sh[7:1];
          hit = !nack_in && (dev == 7'h50 || dev == 7'h2c || dev == 7'h48);
          rv = dev == 7'h50 ? ee[ptr] : dev == 7'h2c ? {fs, os} : temp_in;
          rd = sh[0] && hit;
        end else if (dev == 7'h2c) begin
          if (nb == 1)
            fs = sh;
          else
            os = sh;
        end else if (nb == 1)
          ptr = sh;
        else if (nb == 2)
          ee[ptr][15:8] = sh;
        else
          ee[ptr][7:0] = sh;
        nb = nb + 1;
        sda_oe_n_out = !hit;
      end else
        sda_oe_n_out = 1'b1;
    end else begin
      if (bc == 9) begin
        bc = 0;
        ob = rv[15:8];
        rv = rv << 8;
      end
      sda_oe_n_out = !(rd && !ob[7 - bc]);
    end
  end
endmodule
`default_nettype wire

// >>> csm_manager_tb.sv
// self-checking bench of the calibration serial manager
`timescale 1ns/10ps
`default_nettype none
module csm_manager_tb
  import csm_pkg::*;
;
  logic        clk = 0, lclk = 0, rst_n = 0, wr = 0, rd = 0, nack = 0;
  logic [7:0]  addr = 8'h00;
  logic [15:0] wdata = 16'h0000, temp = 16'hf600;
  logic [15:0] rdata, v;
  logic [7:0]  degc;
  logic        scl_oe_n, sda_oe_n, p_oe_n, io_oe_n;
  logic        scl_o, sda_o, io_o, p_cs, p_clk;
  // open-drain pins: released means pulled up
  wire         scl = scl_oe_n ? 1'b1 : scl_o;
  wire         sda = (sda_oe_n ? 1'b1 : sda_o) & p_oe_n;
  wire         io  = io_oe_n ? 1'b1 : io_o;
  int          n_errors = 0, tests_run = 0;
  csm_manager #(.POLL_CYCLES(2000), .QDIV(2)) uut (
    .clk_in(clk), .rst_n_in(rst_n), .link_clk_in(lclk),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr),
    .reg_rd_in(rd), .reg_rdata_out(rdata), .scl_out(scl_o),
    .scl_oe_n_out(scl_oe_n), .sda_in(sda), .sda_out(sda_o),
    .sda_oe_n_out(sda_oe_n), .prom_cs_out(p_cs), .prom_clk_out(p_clk),
    .prom_serial_io_in(io), .prom_serial_io_out(io_o),
    .prom_serial_io_oe_n_out(io_oe_n), .temp_degc_out(degc));
  csm_i2c_model p (.scl_in(scl), .sda_in(sda), .sda_oe_n_out(p_oe_n),
    .nack_in(nack), .temp_in(temp));
  initial forever #12.5 clk = ~clk;
  initial begin
    #7;
    forever #16 lclk = ~lclk;
  end
  task automatic finish_test();
    if (n_errors == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic give_up();
    n_errors++;
    finish_test();
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk) #2;
    addr = a;
    wdata = d;
    wr = 1;
    @(posedge clk) #2;
    wr = 0;
  endtask
  task automatic rreg(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk) #2;
    addr = a;
    rd = 1;
    @(posedge clk) #2;
    rd = 0;
    d = rdata;
  endtask
  task automatic wait_done();
    for (int i = 0; i < 3000; i++) begin
      rreg(REG_EE_CTL, v);
      if (v[15] === 1'b1)
        return;
    end
    give_up();
  endtask
  task automatic wait_temp(input logic [7:0] e);
    for (int i = 0; i < 6000 && degc !== e; i++)
      @(negedge clk);
    if (degc !== e)
      give_up();
  endtask
  initial begin
    repeat (16) @(posedge clk);
    // pots hold a value other than the reset one, so read-back shows
    p.os = 8'h7e;
    #2;
    rst_n = 1;
    rreg(REG_TRIM, v);
    chk(v, 16'h8080);
    wait_done();
    rreg(REG_TRIM, v);
    chk(v, 16'h807e);
    wreg(REG_TRIM, 16'h1234);
    rreg(REG_EE_CTL, v);
    chk(v & 16'h8000, 16'h0000);
    wait_done();
    chk({p.fs, p.os}, 16'h1234);
    rreg(REG_TRIM, v);
    chk(v, 16'h1234);
    wreg(REG_EE_WORD, 16'hbeef);
    wreg(REG_EE_CTL, 16'h200a);
    rreg(REG_EE_CTL, v);
    chk(v & 16'h8000, 16'h0000);
    wait_done();
    chk(p.ee[5], 16'hbeef);
    // store settle time, scaled down: the model stores at once
    repeat (200) @(posedge clk);
    rreg(REG_EE_CTL, v);
    chk(v, 16'h800a);
    p.ee[7] = 16'h5a3c;
    wreg(REG_EE_CTL, 16'h100e);
    wreg(REG_EE_CTL, 16'h2014);
    wait_done();
    rreg(REG_EE_WORD, v);
    chk(v, 16'h5a3c);
    rreg(REG_EE_CTL, v);
    chk(v, 16'h800e);
    nack = 1;
    wreg(REG_EE_CTL, 16'h100e);
    wait_done();
    rreg(REG_EE_CTL, v);
    chk(v, 16'hc00e);
    nack = 0;
    wait_temp(8'hf6);
    rreg(REG_TEMP, v);
    chk(v, 16'h03d8);
    wreg(REG_TEMP, 16'h8000);
    // let a poll already on the bus finish before the sensor moves
    repeat (500) @(posedge clk);
    temp = 16'h2800;
    // two and a half poll periods with polls held off
    repeat (5000) @(posedge clk);
    rreg(REG_TEMP, v);
    chk(v, 16'h83d8);
    wreg(REG_TEMP, 16'h0000);
    wait_temp(8'h28);
    for (int i = 0; i < 2; i++) begin
      wreg(REG_PROM, i ? 16'h0001 : 16'h0006);
      repeat (4) @(posedge clk);
      chk({p_cs, p_clk, io}, i ? 16'h0001 : 16'h0006);
      rreg(REG_PROM, v);
      chk(v, i ? 16'h0001 : 16'h0006);
    end
    rreg(8'h10, v);
    chk(v, 16'h0000);
    finish_test();
  end
endmodule
`default_nettype wire
